// file: common/phy_power_control_defines.svh
// Register indices, field positions, reset values and timing constants
`ifndef PHY_POWER_CONTROL_DEFINES_SVH
`define PHY_POWER_CONTROL_DEFINES_SVH

// ======================================================================
// Bus geometry
`define AXI_ADDR_W 12
`define REG_IDX_W 10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ======================================================================
// Register indices (byte address is four times the index)
`define IDX_SLEEP_WAKE 10'h0d6
`define IDX_PHY_RESET 10'h0d8
`define IDX_BASIC_CTRL 10'h0e4
`define IDX_BASIC_STAT 10'h0e6
`define IDX_POWER_MODE 10'h0c0
`define IDX_GLOBAL_RESET 10'h0c2

// ======================================================================
// Reset values and writable masks
`define SLEEP_WAKE_RESET 16'h080c
`define BASIC_CTRL_RESET 16'h3120
`define BASIC_CTRL_WMASK 16'h7f3f
`define PHY_RESET_WMASK 16'hfffe
`define BASIC_STAT_FIXED 16'h7808

// ======================================================================
// Field positions
`define WAKE_MSB 15
`define WAKE_LSB 8
`define SLEEP_MSB 7
`define SLEEP_LSB 0
`define PHY_RESET_BIT 0
`define CTRL_LOOPBACK 14
`define CTRL_FORCE_100 13
`define CTRL_AN_ENABLE 12
`define CTRL_AN_RESTART 9
`define CTRL_FORCE_FULL 8
`define CTRL_XOVER_SCHEME 5
`define CTRL_FORCE_XOVER 4
`define CTRL_NO_AUTO_XOVER 3
`define CTRL_TX_DISABLE 1
`define CTRL_LED_OFF 0
`define STAT_AN_DONE 5
`define STAT_LINK_UP 2
`define MODE_MSB 1
`define MODE_LSB 0
`define MODE_LOW_POWER_BIT 8

// ======================================================================
// Timing
`define CLK_MHZ 100
`define TICK_TIME_US 1000
`define WAKE_UNIT_MS 16
`define SLEEP_UNIT_MS 1000
`define MS_COUNT_W 18

`endif

// file: common/phy_power_control_pkg.sv
// Types shared by the PHY power and control register block
package phy_power_control_pkg;

  // Power management mode encodings
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_ENERGY_DETECT = 2'h1,
    MODE_SOFT_POWER_DOWN = 2'h2,
    MODE_POWER_SAVING = 2'h3
  } pm_mode_t;

  // Power state, one-hot
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b01,
    PWR_LOW = 2'b10
  } pwr_state_t;

  // Control levels toward the PHY
  typedef struct packed {
    logic loopback;
    logic force_100;
    logic an_enable;
    logic an_restart;
    logic force_full;
    logic crossover_scheme_select;
    logic force_crossover;
    logic no_auto_crossover;
    logic tx_disable;
    logic led_off;
  } phy_ctrl_t;

  // Live status from the PHY
  typedef struct packed {
    logic energy;
    logic an_done;
    logic link_up;
  } phy_stat_t;

endpackage

// file: hw/phy_power_control_regs.sv
// AXI4-Lite register block for PHY power management and basic control
`include "phy_power_control_defines.svh"

// Functional notes
// RULE1: Mode 00 normal, 01 energy detect
// RULE2: Mode 10 soft power down, 11 power saving
// RULE3: Energy detect wakes on energy or host read
// RULE4: Soft power down wakes only on host read
// RULE5: Wake field resets 0x08, 16 ms units
// RULE6: Wake after energy held for wake time
// RULE7: Sleep field resets 0x0C, 1 s units
// RULE8: Sleep after no energy for sleep time
// RULE9: Software never programs zero timer fields
// RULE10: Write one pulses PHY reset, self clearing
// RULE11: Bit 14 loops host data through PHY
// RULE12: Bit 13 forces 100 or 10, resets one
// RULE13: Bit 12 enables auto-negotiation, resets one
// RULE14: Bit 9 restarts auto-negotiation
// RULE15: Bit 8 forces duplex without negotiation
// RULE16: Bits 5,4,3 control crossover behaviour
// RULE17: Bit 1 disables the transmitter
// RULE18: Bit 0 turns all LEDs off
// RULE19: Status shows fixed capability bits
// RULE20: Status bit 5 shows negotiation complete
// RULE21: Status bit 2 shows link up
// RULE22: Timers use prescaled ticks, restart on change
module phy_power_control_regs
  import phy_power_control_pkg::*;
#(
  parameter int MS_CYCLES = `TICK_TIME_US * `CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire phy_stat_t phy_stat,
  output phy_ctrl_t phy_ctrl,
  output logic phy_reset_pulse,
  output logic low_power,
  output logic power_saving
);

  // ====================================================================
  // Bus and register state
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [`AXI_ADDR_W-1:0] awaddr_q, next_awaddr_q;
  logic [31:0] wdata_q, next_wdata_q;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [15:0] sleep_wake_timing, next_sleep_wake_timing;
  logic [15:0] phy_block_reset, next_phy_block_reset;
  logic [15:0] phy_basic_control, next_phy_basic_control;
  pm_mode_t mode, next_mode;
  logic next_phy_reset_pulse;
  logic [15:0] basic_status;
  logic [`REG_IDX_W-1:0] widx, ridx;
  logic do_write, ar_take, host_wake;
  logic [15:0] wdata16;
  logic [1:0] wstrb16;

  // ====================================================================
  // Power state and timer state
  pwr_state_t state, next_state;
  logic energy_prev, next_energy_prev;
  logic [31:0] prescale, next_prescale;
  logic [`MS_COUNT_W-1:0] ms_count, next_ms_count;
  logic ms_tick, restart;
  logic [`MS_COUNT_W-1:0] wake_limit, sleep_limit;
  localparam logic [31:0] PRESCALE_LAST = 32'(MS_CYCLES - 1);

  // Merge byte lanes of the low half word under a writable mask
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0] strb,
    input logic [15:0] mask
  );
    logic [15:0] sel;
    sel = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    lane_merge = (old_val & ~sel) | (new_val & sel);
  endfunction

  // Handshake outputs and decode
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign widx = awaddr_q[`AXI_ADDR_W-1:2];
  assign ridx = s_axi_araddr[`AXI_ADDR_W-1:2];
  assign do_write = aw_held && w_held && !bvalid;
  assign ar_take = s_axi_arvalid && !rvalid;
  assign host_wake = ar_take && (ridx == `IDX_GLOBAL_RESET); // RULE3 RULE4
  assign wdata16 = wdata_q[15:0];
  assign wstrb16 = wstrb_q[1:0];

  // Fixed capabilities merged with live negotiation and link status
  always_comb begin
    basic_status = `BASIC_STAT_FIXED; // RULE19
    basic_status[`STAT_AN_DONE] = phy_stat.an_done; // RULE20
    basic_status[`STAT_LINK_UP] = phy_stat.link_up; // RULE21
  end

  // Next values of the bus slave and the register file
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr_q = awaddr_q;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_sleep_wake_timing = sleep_wake_timing;
    next_phy_block_reset = phy_block_reset;
    next_phy_basic_control = phy_basic_control;
    next_mode = mode;
    next_phy_reset_pulse = 1'b0;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_wdata_q = s_axi_wdata;
      next_wstrb_q = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      case (widx)
        `IDX_SLEEP_WAKE: begin
          next_sleep_wake_timing = lane_merge(sleep_wake_timing, wdata16,
            wstrb16, 16'hffff);
        end
        `IDX_PHY_RESET: begin
          next_phy_block_reset = lane_merge(phy_block_reset, wdata16,
            wstrb16, `PHY_RESET_WMASK);
          next_phy_reset_pulse = wstrb16[0] &&
            wdata16[`PHY_RESET_BIT]; // RULE10
        end
        `IDX_BASIC_CTRL: begin
          next_phy_basic_control = lane_merge(phy_basic_control, wdata16,
            wstrb16, `BASIC_CTRL_WMASK);
        end
        `IDX_POWER_MODE: begin
          if (wstrb16[0]) begin
            next_mode = pm_mode_t'(wdata16[`MODE_MSB:`MODE_LSB]);
          end
        end
        `IDX_BASIC_STAT, `IDX_GLOBAL_RESET: begin
          next_bresp = `RESP_OKAY;
        end
        default: begin
          next_bresp = `RESP_SLVERR;
        end
      endcase
    end
    // A host wake out of soft power down drops back to normal mode
    if (host_wake && state == PWR_LOW && mode == MODE_SOFT_POWER_DOWN) begin
      next_mode = MODE_NORMAL; // RULE4
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      next_rdata = 32'h0;
      case (ridx)
        `IDX_SLEEP_WAKE: next_rdata[15:0] = sleep_wake_timing;
        `IDX_PHY_RESET: begin
          next_rdata[15:0] = phy_block_reset & `PHY_RESET_WMASK; // RULE10
        end
        `IDX_BASIC_CTRL: next_rdata[15:0] = phy_basic_control;
        `IDX_BASIC_STAT: next_rdata[15:0] = basic_status;
        `IDX_POWER_MODE: begin
          next_rdata[`MODE_MSB:`MODE_LSB] = mode;
          next_rdata[`MODE_LOW_POWER_BIT] = (state == PWR_LOW);
        end
        `IDX_GLOBAL_RESET: next_rdata = 32'h0;
        default: next_rresp = `RESP_SLVERR;
      endcase
    end
  end

  // Register the bus slave and the register file
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h0;
      sleep_wake_timing <= `SLEEP_WAKE_RESET; // RULE5 RULE7
      phy_block_reset <= 16'h0;
      phy_basic_control <= `BASIC_CTRL_RESET; // RULE12 RULE13 RULE16
      mode <= MODE_NORMAL;
      phy_reset_pulse <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      sleep_wake_timing <= next_sleep_wake_timing;
      phy_block_reset <= next_phy_block_reset;
      phy_basic_control <= next_phy_basic_control;
      mode <= next_mode;
      phy_reset_pulse <= next_phy_reset_pulse;
    end
  end

  // Control levels straight from the control register flops
  assign phy_ctrl.loopback = phy_basic_control[`CTRL_LOOPBACK]; // RULE11
  assign phy_ctrl.force_100 = phy_basic_control[`CTRL_FORCE_100]; // RULE12
  assign phy_ctrl.an_enable = phy_basic_control[`CTRL_AN_ENABLE]; // RULE13
  assign phy_ctrl.an_restart = phy_basic_control[`CTRL_AN_RESTART]; // RULE14
  assign phy_ctrl.force_full = phy_basic_control[`CTRL_FORCE_FULL]; // RULE15
  assign phy_ctrl.crossover_scheme_select =
    phy_basic_control[`CTRL_XOVER_SCHEME]; // RULE16
  assign phy_ctrl.force_crossover = phy_basic_control[`CTRL_FORCE_XOVER];
  assign phy_ctrl.no_auto_crossover =
    phy_basic_control[`CTRL_NO_AUTO_XOVER]; // RULE16
  assign phy_ctrl.tx_disable = phy_basic_control[`CTRL_TX_DISABLE]; // RULE17
  assign phy_ctrl.led_off = phy_basic_control[`CTRL_LED_OFF]; // RULE18
  assign low_power = (state == PWR_LOW);
  assign power_saving = (mode == MODE_POWER_SAVING); // RULE2

  // ====================================================================
  // Timers: millisecond prescaler and elapsed count since last change
  assign restart = (phy_stat.energy != energy_prev) ||
    (next_state != state); // RULE22
  assign ms_tick = (prescale == PRESCALE_LAST);
  assign wake_limit = `MS_COUNT_W'(sleep_wake_timing[`WAKE_MSB:`WAKE_LSB]
    * `WAKE_UNIT_MS); // RULE5
  assign sleep_limit = `MS_COUNT_W'(sleep_wake_timing[`SLEEP_MSB:`SLEEP_LSB]
    * `SLEEP_UNIT_MS); // RULE7

  // Next power state; a zero timer field would act at once (RULE9)
  always_comb begin
    next_state = state;
    next_energy_prev = phy_stat.energy;
    case (state)
      PWR_NORMAL: begin
        if (mode == MODE_SOFT_POWER_DOWN) begin
          next_state = PWR_LOW; // RULE2
        end else if (mode == MODE_ENERGY_DETECT && !phy_stat.energy &&
                     ms_count >= sleep_limit) begin
          next_state = PWR_LOW; // RULE8
        end
      end
      PWR_LOW: begin
        if (host_wake) begin
          next_state = PWR_NORMAL; // RULE3 RULE4
        end else if (mode == MODE_ENERGY_DETECT && phy_stat.energy &&
                     ms_count >= wake_limit) begin
          next_state = PWR_NORMAL; // RULE6
        end else if (mode == MODE_NORMAL || mode == MODE_POWER_SAVING) begin
          next_state = PWR_NORMAL; // RULE1
        end
      end
      default: next_state = PWR_NORMAL;
    endcase
  end

  // Next values of the prescaler and the millisecond count
  always_comb begin
    next_prescale = prescale + 32'h1;
    next_ms_count = ms_count;
    if (restart) begin
      next_prescale = 32'h0; // RULE22
      next_ms_count = '0;
    end else if (ms_tick) begin
      next_prescale = 32'h0;
      if (ms_count != '1) begin
        next_ms_count = ms_count + `MS_COUNT_W'(1);
      end
    end
  end

  // Register power state and timers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= PWR_NORMAL;
      energy_prev <= 1'b0;
      prescale <= 32'h0;
      ms_count <= '0;
    end else begin
      state <= next_state;
      energy_prev <= next_energy_prev;
      prescale <= next_prescale;
      ms_count <= next_ms_count;
    end
  end

  // ====================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_reset_write;
    do_write && widx == `IDX_PHY_RESET && wstrb16[0] &&
    wdata16[`PHY_RESET_BIT];
  endsequence

  sequence s_pulse_once;
    phy_reset_pulse ##1 !phy_reset_pulse;
  endsequence

  a_phy_reset_pulse: assert property (s_reset_write |=> s_pulse_once) // RULE10
    else $error("PHY reset pulse not a single cycle after write");

  a_reset_reads_zero: assert property ( // RULE10
    ar_take && ridx == `IDX_PHY_RESET |=> !s_axi_rdata[0])
    else $error("PHY reset bit did not read as zero");

  a_normal_stays_up: assert property ( // RULE1
    mode == MODE_NORMAL |=> !low_power)
    else $error("Low power state entered in normal mode");

  a_soft_down_entry: assert property ( // RULE2
    mode == MODE_SOFT_POWER_DOWN && !low_power && !host_wake |=> low_power)
    else $error("Soft power down did not enter low power");

  a_soft_down_hold: assert property ( // RULE4
    low_power && mode == MODE_SOFT_POWER_DOWN && !host_wake |=> low_power)
    else $error("Soft power down woke without a host read");

  a_host_wake: assert property ( // RULE3
    low_power && host_wake |=> !low_power ##1 mode != MODE_SOFT_POWER_DOWN)
    else $error("Host read of global reset did not wake");

  a_wake_time: assert property ( // RULE6
    $fell(low_power) && $past(mode) == MODE_ENERGY_DETECT &&
    !$past(host_wake) |-> $past(ms_count) >= $past(wake_limit) &&
    $past(phy_stat.energy))
    else $error("Woke before energy held for the wake time");

  a_sleep_time: assert property ( // RULE8
    $rose(low_power) && $past(mode) == MODE_ENERGY_DETECT |->
    $past(ms_count) >= $past(sleep_limit) && !$past(phy_stat.energy))
    else $error("Slept before quiet held for the sleep time");

  a_timer_restart: assert property ( // RULE22
    phy_stat.energy != energy_prev |=> ms_count == '0 && prescale == 32'h0)
    else $error("Timer did not restart on energy change");

  a_status_bits: assert property ( // RULE19
    ar_take && ridx == `IDX_BASIC_STAT |=>
    s_axi_rdata[15:0] == ((`BASIC_STAT_FIXED) |
    {10'h0, $past(phy_stat.an_done), 2'h0, $past(phy_stat.link_up), 2'h0}))
    else $error("Basic status read wrong"); // RULE20 RULE21

  a_ctrl_write: assert property ( // RULE11
    do_write && widx == `IDX_BASIC_CTRL && wstrb16[1] |=>
    phy_ctrl.loopback == $past(wdata16[`CTRL_LOOPBACK]) &&
    phy_ctrl.an_enable == $past(wdata16[`CTRL_AN_ENABLE]))
    else $error("Control write did not reach the PHY levels"); // RULE13

endmodule // phy_power_control_regs

// file: bench/tb.sv
// Self-checking testbench for the PHY power and control register block
`include "phy_power_control_defines.svh"

module tb
  import phy_power_control_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ======================================================================
  // Signals and design instance
  localparam int MS = 4;
  logic clk;
  logic reset;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  phy_stat_t stat;
  phy_ctrl_t ctrl;
  logic pulse, low_power, power_saving;
  int errors, comparisons, pulses;

  phy_power_control_regs #(.MS_CYCLES(MS)) i_dut (
    .clk(clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .phy_stat(stat), .phy_ctrl(ctrl),
    .phy_reset_pulse(pulse), .low_power(low_power),
    .power_saving(power_saving)
  );

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count cycles with the PHY reset pulse high
  always @(posedge clk) begin
    if (pulse === 1'b1) pulses++;
  end

  // ======================================================================
  // Checking and closing
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_range(input string what, input int n, input int lo,
                             input int hi);
    comparisons++;
    if (n < lo || n > hi) begin
      errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ======================================================================
  // Register bus master
  task automatic wr(input logic [9:0] idx, input logic [15:0] d,
                    output logic [1:0] resp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge clk); // Idle edge before the next transfer
  endtask

  task automatic rd(input logic [9:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk); // Idle edge before the next transfer
  endtask

  // Wait until low_power reaches a level, counting edges
  task automatic wait_lp(input logic lvl, output int n);
    n = 0;
    while (low_power !== lvl && n < 6000) begin
      @(posedge clk);
      n++;
    end
  endtask

  function automatic logic [9:0] ctrl_map(input logic [15:0] c);
    return {c[14], c[13], c[12], c[9], c[8], c[5], c[4], c[3], c[1], c[0]};
  endfunction

  // ======================================================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    check("ctrl_port", 32'h1b0, 32'(ctrl));
    rd(`IDX_SLEEP_WAKE, d, r);
    check("sleep_wake", 32'h080c, d);
    check("read_resp", 32'(`RESP_OKAY), 32'(r));
    wr(10'h000, 16'h1234, r);
    check("unmapped_bresp", 32'(`RESP_SLVERR), 32'(r));
    rd(`IDX_BASIC_CTRL, d, r);
    check("basic_ctrl", 32'h3120, d);
    rd(10'h000, d, r);
    check("unmapped_data", 32'h0, d);
    check("unmapped_resp", 32'(`RESP_SLVERR), 32'(r));
    $display("test reset done");
  endtask

  task automatic t_ctrl;
    int pos[10] = '{14, 13, 12, 9, 8, 5, 4, 3, 1, 0};
    logic [15:0] v;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 10; i++) begin
      v = 16'h0001 << pos[i];
      wr(`IDX_BASIC_CTRL, v, r);
      rd(`IDX_BASIC_CTRL, d, r);
      check("ctrl_read", {16'h0000, v}, d);
      check("ctrl_port", 32'(ctrl_map(v)), 32'(ctrl));
    end
    wr(`IDX_BASIC_CTRL, 16'hffff, r);
    check("write_bresp", 32'(`RESP_OKAY), 32'(r));
    rd(`IDX_BASIC_CTRL, d, r);
    check("ctrl_mask", 32'h7f3f, d);
    $display("test control done");
  endtask

  task automatic t_status;
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      stat <= {1'b0, 2'(i)};
      rd(`IDX_BASIC_STAT, d, r);
      e = 32'h7808 | {26'h0, i[1], 2'h0, i[0], 2'h0};
      check("status", e, d);
    end
    stat <= 3'b000;
    $display("test status done");
  endtask

  task automatic t_phy_reset;
    logic [31:0] d;
    logic [1:0] r;
    pulses = 0;
    wr(`IDX_PHY_RESET, 16'ha5a5, r);
    repeat (3) @(posedge clk);
    check("pulse_count", 32'd1, 32'(pulses));
    rd(`IDX_PHY_RESET, d, r);
    check("reset_read", 32'ha5a4, d);
    wr(`IDX_PHY_RESET, 16'h0002, r);
    repeat (3) @(posedge clk);
    check("pulse_count", 32'd1, 32'(pulses));
    $display("test phy reset done");
  endtask

  task automatic t_modes;
    logic [31:0] d;
    logic [1:0] r;
    wr(`IDX_POWER_MODE, 16'h0003, r);
    repeat (3) @(posedge clk);
    check("power_saving", 32'd1, 32'(power_saving));
    check("low_power", 32'd0, 32'(low_power));
    wr(`IDX_POWER_MODE, 16'h0000, r);
    repeat (3) @(posedge clk);
    check("power_saving", 32'd0, 32'(power_saving));
    wr(`IDX_POWER_MODE, 16'h0002, r);
    repeat (3) @(posedge clk);
    check("low_power", 32'd1, 32'(low_power));
    rd(`IDX_POWER_MODE, d, r);
    check("mode_read", 32'h0102, d);
    stat <= 3'b100;
    repeat (100) @(posedge clk);
    check("low_power", 32'd1, 32'(low_power));
    rd(`IDX_GLOBAL_RESET, d, r);
    repeat (3) @(posedge clk);
    check("low_power", 32'd0, 32'(low_power));
    rd(`IDX_POWER_MODE, d, r);
    check("mode_read", 32'h0000, d);
    stat <= 3'b000;
    $display("test modes done");
  endtask

  task automatic t_energy;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(`IDX_SLEEP_WAKE, 16'h0101, r);
    wr(`IDX_POWER_MODE, 16'h0001, r);
    stat <= 3'b100;
    repeat (5) @(posedge clk);
    stat <= 3'b000;
    wait_lp(1'b1, n);
    check_range("sleep_cycles", n, 3990, 4020);
    stat <= 3'b100;
    repeat (40) @(posedge clk);
    check("low_power", 32'd1, 32'(low_power));
    stat <= 3'b000;
    repeat (5) @(posedge clk);
    stat <= 3'b100;
    wait_lp(1'b0, n);
    check_range("wake_cycles", n, 58, 75);
    stat <= 3'b000;
    wait_lp(1'b1, n);
    check_range("sleep_cycles", n, 3990, 4020);
    rd(`IDX_GLOBAL_RESET, d, r);
    repeat (3) @(posedge clk);
    check("low_power", 32'd0, 32'(low_power));
    wr(`IDX_POWER_MODE, 16'h0000, r);
    $display("test energy detect done");
  endtask

  // ======================================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    stat = 3'b000;
    errors = 0;
    comparisons = 0;
    pulses = 0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_ctrl();
    t_status();
    t_phy_reset();
    t_modes();
    t_energy();
    summarize();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    summarize();
  end

endmodule // tb
